// ---- bench/sosr_mgmt_host.sv ----
// Management controller model for the indirect register pair.
// Assumes strobes are taken on rising clk, read data one cycle later.
`timescale 1ns/100ps
module sosr_mgmt_host
   import sosr_pkg::*;
(
   input wire logic clk,
   output logic [4:0] mgmt_reg,
   output logic mgmt_wr,
   output logic mgmt_rd,
   output logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata
);
   // ****************
   // Bus cycles
   // ****************
   initial begin
      mgmt_reg = 5'h1f;
      mgmt_wr = 1'b0;
      mgmt_rd = 1'b0;
      mgmt_wdata = 16'h0;
   end
   task automatic wr(input logic [4:0] r, input logic [15:0] d);
      @(posedge clk);
      #1 mgmt_reg = r;
      mgmt_wdata = d;
      mgmt_wr = 1'b1;
      @(posedge clk);
      #1 mgmt_wr = 1'b0;
      mgmt_wdata = ~d; // Stale data must not look valid
   endtask
   task automatic rd(input logic [4:0] r, output logic [15:0] d);
      @(posedge clk);
      #1 mgmt_reg = r;
      mgmt_rd = 1'b1;
      @(posedge clk);
      #1 mgmt_rd = 1'b0;
      d = mgmt_rdata;
   endtask
   task automatic sel(input logic [4:0] dv, input logic [15:0] a, input logic [1:0] op);
      wr(SOSR_REG_IND_CTRL, {11'h0, dv});
      wr(SOSR_REG_IND_DATA, a);
      wr(SOSR_REG_IND_CTRL, {op, 9'h0, dv});
   endtask
endmodule // sosr_mgmt_host

// ---- bench/sosr_regs_properties.sv ----
// Port checker for the strap override register bank.
// Assumes straps settle within seven cycles of reset release.
`timescale 1ns/100ps
module sosr_regs_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire logic [15:0] mgmt_rdata,
   input wire logic led_style_select,
   input wire logic ref_clock_out_enable,
   input wire logic chip_power_down,
   input wire logic [4:0] mgmt_address,
   input wire logic wake_event_out_a,
   input wire logic indicator_one,
   input wire logic wake_event_out_b,
   input wire logic interrupt_out
);
   // ****************
   // Helper state
   // ****************
   logic [2:0] age;
   logic [3:0] wr_hist;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         age <= 3'h0;
      end else if (age != 3'h7) begin
         age <= age + 3'h1;
      end
   end
   // Writes of the last four cycles excuse an output change
   always_ff @(posedge clk) begin
      wr_hist <= {wr_hist[2:0], mgmt_wr};
   end
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence quiet4;
      (age == 3'h7 && !mgmt_wr) [*4];
   endsequence
   chk_addr_upper: assert property (mgmt_address[4:3] == 2'h0)
      else $error("upper address bits not zero");
   chk_addr_held: assert property (age == 3'h7 |-> $stable(mgmt_address))
      else $error("address strap moved");
   chk_rdata_hold: assert property (!mgmt_rd |=> $stable(mgmt_rdata))
      else $error("read data changed without read");
   chk_led_cause: assert property (age == 3'h7 && $changed(led_style_select) |-> |wr_hist)
      else $error("led style changed without write");
   chk_clk_cause: assert property (age == 3'h7 && wr_hist == 4'h0 |->
      $stable(ref_clock_out_enable)) else $error("clock enable changed without write");
   chk_pwrdn_cause: assert property (quiet4 |=> $stable(chip_power_down))
      else $error("power-down changed without write");
   chk_wake_cause: assert property (age == 3'h7 &&
      $changed({wake_event_out_a, wake_event_out_b}) |-> |wr_hist)
      else $error("wake output changed without write");
   chk_func_pair: assert property (indicator_one == interrupt_out)
      else $error("pin functions disagree");
endmodule // sosr_regs_properties
bind sosr_regs sosr_regs_properties u_props (.clk(clk), .rst_n(rst_n), .mgmt_wr(mgmt_wr),
   .mgmt_rd(mgmt_rd), .mgmt_rdata(mgmt_rdata), .led_style_select(led_style_select),
   .ref_clock_out_enable(ref_clock_out_enable), .chip_power_down(chip_power_down),
   .mgmt_address(mgmt_address), .wake_event_out_a(wake_event_out_a),
   .indicator_one(indicator_one), .wake_event_out_b(wake_event_out_b),
   .interrupt_out(interrupt_out));

// ---- bench/tb_top.sv ----
// Self-checking bench for the strap override register bank.
// Assumes the host model owns the management port.
`timescale 1ns/100ps
module tb_top
   import sosr_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n, led, ck, pd, mwr, mrd, lss, rce, cpd, wa, ind, wb, irq;
   logic [2:0] ad;
   logic [4:0] mreg, maddr;
   logic [15:0] bc, d, r, q, m_cc, m_ss, m_5a, mwd, mrdat;
   logic [15:0] ex[3];
   logic [31:0] seed;
   int mismatches, check_count, cycles;
   sosr_regs dut (.clk(clk), .rst_n(rst_n), .led_style_pin(led), .ref_clk_en_pin(ck),
      .pwrdn_pin(pd), .addr_pin(ad), .basic_ctrl(bc), .mgmt_reg(mreg), .mgmt_wr(mwr),
      .mgmt_rd(mrd), .mgmt_wdata(mwd), .mgmt_rdata(mrdat), .led_style_select(lss),
      .ref_clock_out_enable(rce), .chip_power_down(cpd), .mgmt_address(maddr),
      .wake_event_out_a(wa), .indicator_one(ind), .wake_event_out_b(wb), .interrupt_out(irq));
   sosr_mgmt_host host (.clk(clk), .mgmt_reg(mreg), .mgmt_wr(mwr), .mgmt_rd(mrd),
      .mgmt_wdata(mwd), .mgmt_rdata(mrdat));
   // ****************
   // Helpers
   // ****************
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rdm(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] e,
      input string nm);
      host.sel(dv, a, 2'h1);
      host.rd(SOSR_REG_IND_DATA, d);
      chk(d, e, nm);
   endtask
   task automatic wrm(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] v);
      host.sel(dv, a, 2'h1);
      host.wr(SOSR_REG_IND_DATA, v);
   endtask
   task automatic final_report();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      mismatches = 0;
      check_count = 0;
      cycles = 0;
      rst_n = 1'b0;
      bc = 16'h2100;
      seed = lfsr(32'hfcc95674);
      {led, ck, pd, ad} = seed[5:0];
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk);
      #1 m_ss = {8'h0, led, 1'b0, ck, 2'h0, ad};
      m_cc = {11'h0, 1'b0, led, 1'b0, ck, 1'b0};
      m_5a = 16'h0108;
      chk(16'(maddr), 16'(ad), "address");
      chk(16'({lss, rce, cpd}), 16'({led, ck, pd}), "strap outputs");
      rdm(5'h2, 16'h1, m_ss, "strap status");
      rdm(5'h2, 16'h0, m_cc, "common control");
      rdm(5'h2, 16'h2, {8'h0, pd, 7'h0}, "op mode");
      rdm(5'h1, 16'h5a, m_5a, "link time");
      rdm(5'h2, 16'h5, 16'h0, "unmapped");
      // Link time hidden and frozen unless forced 100 Mbps
      bc = seed[31:16] | 16'h0001;
      rdm(5'h1, 16'h5a, m_5a & 16'hfff1, "link time gated");
      wrm(5'h1, 16'h5a, 16'hffff);
      bc = 16'h2100;
      rdm(5'h1, 16'h5a, 16'h01f9, "link time kept");
      wrm(5'h1, 16'h5a, 16'h0000);
      rdm(5'h1, 16'h5a, 16'h0, "link time written");
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         r = seed[15:0];
         q = seed[31:16];
         wrm(5'h2, 16'h0, r);
         wrm(5'h2, 16'h2, q);
         wrm(5'h2, 16'h1, r);
         wrm(5'h2, 16'h10, {k[1:0], 14'h0});
         m_cc = {r[15:5], 1'b0, r[4], 1'b0, r[1:0]};
         repeat (2) @(posedge clk);
         #1 chk(16'({lss, rce, cpd}), 16'({r[4], r[1], q[7]}), "overrides");
         chk(16'({wa, ind, wb, irq}), 16'({q[8] & !k[0], k[0] ^ k[1], q[10] & !k[0],
            k[0] ^ k[1]}), "wake pins");
         rdm(5'h2, 16'h0, m_cc, "common control rw");
         rdm(5'h2, 16'h2, q, "op mode rw");
         rdm(5'h2, 16'h1, m_ss, "strap status held");
      end
      ex = '{m_cc, m_ss, q};
      host.sel(5'h2, 16'h0, 2'h2);
      for (int i = 0; i < 3; i++) begin
         host.rd(SOSR_REG_IND_DATA, d);
         chk(d, ex[i], "read increment");
      end
      host.sel(5'h2, 16'h0, 2'h3);
      for (int i = 0; i < 2; i++) begin
         host.rd(SOSR_REG_IND_DATA, d);
         chk(d, m_cc, "no read increment");
      end
      final_report();
   end
endmodule // tb_top

// ---- src/sosr_pkg.sv ----
// Package for the strap override and status register bank.
// Assumes a clause-22 style management port reaching the indirect pair.
package sosr_pkg;
   // ************************************************************
   // Direct register numbers and forced 100 Mbps code
   // ************************************************************
   localparam logic [4:0] SOSR_REG_BASIC_CTRL = 5'h00;
   localparam logic [4:0] SOSR_REG_IND_CTRL = 5'h0d;
   localparam logic [4:0] SOSR_REG_IND_DATA = 5'h0e;
   localparam logic [15:0] SOSR_FORCE_100_CODE = 16'h2100;
   // ************************************************************
   // Indirect space locations
   // ************************************************************
   localparam logic [4:0] SOSR_DEV_PCS = 5'h01;
   localparam logic [4:0] SOSR_DEV_VENDOR = 5'h02;
   localparam logic [15:0] SOSR_GIGABIT_LINK_UP_TIME_CTRL = 16'h005a;
   localparam logic [15:0] SOSR_COMMON_CONTROL = 16'h0000;
   localparam logic [15:0] SOSR_STRAP_STATUS = 16'h0001;
   localparam logic [15:0] SOSR_OPERATION_MODE_STRAP_OVERRIDE = 16'h0002;
   localparam logic [15:0] SOSR_WAKE_CONTROL = 16'h0010;
   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int SOSR_OP_MSB = 15;
   localparam int SOSR_OP_LSB = 14;
   localparam int SOSR_LINK_TIME_MSB = 3;
   localparam int SOSR_LINK_TIME_LSB = 1;
   localparam logic [2:0] SOSR_LINK_TIME_RST = 3'h4;
   localparam logic [4:0] SOSR_LINK_RSVD_RST = 5'h10;
   localparam int SOSR_CC_LED_OVR = 4;
   localparam int SOSR_CC_LED_STAT = 3;
   localparam int SOSR_CC_CLK_OVR = 1;
   localparam int SOSR_SS_LED = 7;
   localparam int SOSR_SS_CLK = 5;
   localparam int SOSR_OM_WAKE_B_EN = 10;
   localparam int SOSR_OM_WAKE_A_EN = 8;
   localparam int SOSR_OM_PWRDN = 7;
   localparam int SOSR_WK_SEL_MSB = 15;
   localparam int SOSR_WK_SEL_LSB = 14;
   // ************************************************************
   // Indirect operation codes and wake selects
   // ************************************************************
   typedef enum logic [1:0] {
      SOSR_OP_ADDR = 2'h0,
      SOSR_OP_DATA = 2'h1,
      SOSR_OP_INC_RW = 2'h2,
      SOSR_OP_INC_WR = 2'h3
   } sosr_op_type;
   localparam logic [1:0] SOSR_WAKE_ONLY = 2'h0;
   localparam logic [1:0] SOSR_FUNC_ONLY = 2'h1;
   localparam logic [1:0] SOSR_WAKE_AND_FUNC = 2'h2;
endpackage

// ---- src/sosr_regs.sv ----
// Strap override and status registers behind the indirect register pair.
// Assumes a same-clock management port; basic control comes from the core.
`timescale 1ns/100ps
module sosr_regs
   import sosr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic led_style_pin,
   input wire logic ref_clk_en_pin,
   input wire logic pwrdn_pin,
   input wire logic [2:0] addr_pin,
   input wire logic [15:0] basic_ctrl,
   input wire logic [4:0] mgmt_reg,
   input wire logic mgmt_wr,
   input wire logic mgmt_rd,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic led_style_select,
   output logic ref_clock_out_enable,
   output logic chip_power_down,
   output logic [4:0] mgmt_address,
   output logic wake_event_out_a,
   output logic indicator_one,
   output logic wake_event_out_b,
   output logic interrupt_out
);
   sosr_strap_if st ();
   sosr_op_type op;
   logic [4:0] devad;
   logic [15:0] raddr;
   logic [2:0] link_time;
   logic [4:0] link_rsvd;
   logic link_bit0;
   logic [10:0] cc_rsvd;
   logic led_stat;
   logic clk_ovr;
   logic cc_bit0;
   logic [15:0] om;
   logic [1:0] wake_sel;
   logic [15:0] next_rdata;
   logic data_wr;
   logic data_rd;
   logic hit_pcs;
   logic hit_ven;
   logic force_100;

   sosr_strap_sampler u_sampler (
      .clk(clk),
      .rst_n(rst_n),
      .led_style_pin(led_style_pin),
      .ref_clk_en_pin(ref_clk_en_pin),
      .pwrdn_pin(pwrdn_pin),
      .addr_pin(addr_pin),
      .st(st)
   );

   // ************************************************************
   // Indirect access pair
   // ************************************************************
   assign data_wr = mgmt_wr && mgmt_reg == SOSR_REG_IND_DATA && op != SOSR_OP_ADDR;
   assign data_rd = mgmt_rd && mgmt_reg == SOSR_REG_IND_DATA && op != SOSR_OP_ADDR;
   assign hit_pcs = devad == SOSR_DEV_PCS;
   assign hit_ven = devad == SOSR_DEV_VENDOR;
   assign force_100 = basic_ctrl == SOSR_FORCE_100_CODE;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         op <= SOSR_OP_ADDR;
         devad <= 5'h00;
      end else if (mgmt_wr && mgmt_reg == SOSR_REG_IND_CTRL) begin
         op <= sosr_op_type'(mgmt_wdata[SOSR_OP_MSB:SOSR_OP_LSB]);
         devad <= mgmt_wdata[4:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         raddr <= 16'h0000;
      end else if (mgmt_wr && mgmt_reg == SOSR_REG_IND_DATA && op == SOSR_OP_ADDR) begin
         raddr <= mgmt_wdata;
      end else if ((data_rd && op == SOSR_OP_INC_RW)
            || (data_wr && (op == SOSR_OP_INC_RW || op == SOSR_OP_INC_WR))) begin
         raddr <= raddr + 16'h0001;
      end
   end

   // ************************************************************
   // Link-up time control
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_time <= SOSR_LINK_TIME_RST;
         link_rsvd <= SOSR_LINK_RSVD_RST;
         link_bit0 <= 1'b0;
      end else if (data_wr && hit_pcs && raddr == SOSR_GIGABIT_LINK_UP_TIME_CTRL) begin
         link_rsvd <= mgmt_wdata[8:4];
         link_bit0 <= mgmt_wdata[0];
         if (force_100) begin
            link_time <= mgmt_wdata[SOSR_LINK_TIME_MSB:SOSR_LINK_TIME_LSB];
         end
      end
   end

   // ************************************************************
   // Common control
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cc_rsvd <= 11'h000;
         led_stat <= 1'b0;
         clk_ovr <= 1'b0;
         cc_bit0 <= 1'b0;
      end else if (st.load) begin
         led_stat <= st.led_style;
         clk_ovr <= st.ref_clk_en;
      end else if (data_wr && hit_ven && raddr == SOSR_COMMON_CONTROL) begin
         cc_rsvd <= mgmt_wdata[15:5];
         led_stat <= mgmt_wdata[SOSR_CC_LED_OVR];
         clk_ovr <= mgmt_wdata[SOSR_CC_CLK_OVR];
         cc_bit0 <= mgmt_wdata[0];
      end
   end

   // ************************************************************
   // Operation mode override and wake select
   // ************************************************************
   // Low override bits beyond power-down are plain storage here
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         om <= 16'h0000;
      end else if (st.load) begin
         om[SOSR_OM_PWRDN] <= st.pwrdn;
      end else if (data_wr && hit_ven && raddr == SOSR_OPERATION_MODE_STRAP_OVERRIDE) begin
         om <= mgmt_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_sel <= SOSR_WAKE_ONLY;
      end else if (data_wr && hit_ven && raddr == SOSR_WAKE_CONTROL) begin
         wake_sel <= mgmt_wdata[SOSR_WK_SEL_MSB:SOSR_WK_SEL_LSB];
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      next_rdata = 16'h0000;
      if (mgmt_reg == SOSR_REG_IND_CTRL) begin
         next_rdata = {op, 9'h000, devad};
      end else if (mgmt_reg == SOSR_REG_IND_DATA && op == SOSR_OP_ADDR) begin
         next_rdata = raddr;
      end else if (mgmt_reg == SOSR_REG_IND_DATA && hit_pcs
            && raddr == SOSR_GIGABIT_LINK_UP_TIME_CTRL) begin
         // Field reads zero outside the forced mode
         next_rdata = {7'h00, link_rsvd, force_100 ? link_time : 3'h0, link_bit0};
      end else if (mgmt_reg == SOSR_REG_IND_DATA && hit_ven) begin
         case (raddr)
            SOSR_COMMON_CONTROL: begin
               next_rdata = {cc_rsvd, 1'b0, led_stat, 1'b0, clk_ovr, cc_bit0};
            end
            SOSR_STRAP_STATUS: begin
               next_rdata = {8'h00, st.led_style, 1'b0, st.ref_clk_en, 2'h0,
                  st.addr};
            end
            SOSR_OPERATION_MODE_STRAP_OVERRIDE: begin
               next_rdata = om;
            end
            SOSR_WAKE_CONTROL: begin
               next_rdata = {wake_sel, 14'h0000};
            end
            default: begin
               next_rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mgmt_rdata <= 16'h0000;
      end else if (mgmt_rd) begin
         mgmt_rdata <= next_rdata;
      end
   end

   // ************************************************************
   // Steering outputs
   // ************************************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         led_style_select <= 1'b0;
         ref_clock_out_enable <= 1'b0;
         chip_power_down <= 1'b0;
         mgmt_address <= 5'h00;
      end else begin
         led_style_select <= led_stat;
         ref_clock_out_enable <= clk_ovr;
         chip_power_down <= om[SOSR_OM_PWRDN];
         mgmt_address <= {2'h0, st.addr};
      end
   end

   // Reserved select turns both functions off to keep the pins quiet
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wake_event_out_a <= 1'b0;
         indicator_one <= 1'b0;
         wake_event_out_b <= 1'b0;
         interrupt_out <= 1'b0;
      end else begin
         wake_event_out_a <= om[SOSR_OM_WAKE_A_EN]
            && (wake_sel == SOSR_WAKE_ONLY || wake_sel == SOSR_WAKE_AND_FUNC);
         indicator_one <= wake_sel == SOSR_FUNC_ONLY || wake_sel == SOSR_WAKE_AND_FUNC;
         wake_event_out_b <= om[SOSR_OM_WAKE_B_EN]
            && (wake_sel == SOSR_WAKE_ONLY || wake_sel == SOSR_WAKE_AND_FUNC);
         interrupt_out <= wake_sel == SOSR_FUNC_ONLY || wake_sel == SOSR_WAKE_AND_FUNC;
      end
   end
endmodule // sosr_regs

// ---- src/sosr_strap_if.sv ----
// Interface carrying latched strap values from sampler to register bank.
// Assumes one clock; the load pulse lasts one cycle.
`timescale 1ns/100ps
interface sosr_strap_if;
   logic load;
   logic led_style;
   logic ref_clk_en;
   logic pwrdn;
   logic [2:0] addr;
   modport sampler (output load, output led_style, output ref_clk_en, output pwrdn,
      output addr);
   modport consumer (input load, input led_style, input ref_clk_en, input pwrdn,
      input addr);
endinterface

// ---- src/sosr_strap_sampler.sv ----
// Strap pin synchroniser and one-shot latch.
// Assumes strap pins are static around reset release.
`timescale 1ns/100ps
module sosr_strap_sampler
   import sosr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic led_style_pin,
   input wire logic ref_clk_en_pin,
   input wire logic pwrdn_pin,
   input wire logic [2:0] addr_pin,
   sosr_strap_if.sampler st
);
   logic [5:0] meta;
   logic [5:0] sync;
   logic done;
   logic settle;

   // ************************************************************
   // Two-flop synchroniser
   // ************************************************************
   always_ff @(posedge clk) begin
      meta <= {led_style_pin, ref_clk_en_pin, pwrdn_pin, addr_pin};
      sync <= meta;
   end

   // ************************************************************
   // Capture once after release
   // ************************************************************
   // Wait one cycle; the synchroniser then holds pin values sampled at the last edge in reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         settle <= 1'b0;
         done <= 1'b0;
         st.load <= 1'b0;
      end else begin
         settle <= 1'b1;
         st.load <= settle && !done;
         if (settle) begin
            done <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st.led_style <= 1'b0;
         st.ref_clk_en <= 1'b0;
         st.pwrdn <= 1'b0;
         st.addr <= 3'h0;
      end else if (settle && !done) begin
         {st.led_style, st.ref_clk_en, st.pwrdn, st.addr} <= sync;
      end
   end
endmodule // sosr_strap_sampler
